// >>> design/flash_host_ctl.sv
// host controller issuing write cycles and status polling to a parallel flash
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
// What this block does
// - host may strobe oe or ce between reads; both toggle bits update.
// - protect cycle uses address bit six low, bit one high, bit zero low.
// - unprotect cycle uses address bit six high, bit one high, bit zero low.
// - hold reset at high voltage 4 us before the first write.
// - keep reset high voltage 4 us after ready returns; hold starts at first ready after the off request, without waiting for busy.
// - main toggle bit reads at any address; polling bit needs valid one.
module flash_host_ctl
	import flash_ctl_pkg::*;
#(
	parameter int ADDR_W = 22
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// avalon-mm slave
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic irq_out,
	// flash pins
	output flash_pins_s pins_out,
	input wire logic [FLASH_DW-1:0] dq_in,
	input wire logic ready_busy_n_in
);
	if (ADDR_W < 7 || ADDR_W > FLASH_AW)
	begin : g_bad_addr_w
		$error("ADDR_W must lie between 7 and the flash address width");
	end

	state_e state_q;
	logic [15:0] cnt_q;
	logic [1:0] rb_sync_q;
	logic [FLASH_DW-1:0] dq_s1_q, dq_s2_q, samp_q, rdata_q, wdata_q;
	logic [ADDR_W-1:0] addr_q;
	logic [1:0] mode_q;
	logic poll_q, first_q, vid_q, vid_ok_q, tog_main_q, tog_susp_q;
	logic [IRQ_W-1:0] ev_q, irq_stat_q, irq_en_q;
	logic rd_ack_q;
	logic [31:0] rdata_bus_q;
	logic ready;
	logic idle;
	logic wr_ctrl;

	// merge a 32-bit write under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// force the protect or unprotect selection bits onto an address
	function automatic logic [ADDR_W-1:0] prot_addr(
		input logic [ADDR_W-1:0] a, input logic unprot);
		logic [ADDR_W-1:0] r;
		r = a;
		r[6] = unprot; // low for protect, high for unprotect
		r[1] = 1'b1;
		r[0] = 1'b0;
		return r;
	endfunction : prot_addr

	// two-flop synchronisers for pins from the flash
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			rb_sync_q <= 2'h3;
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
		end
		else
		begin
			rb_sync_q <= {rb_sync_q[0], ready_busy_n_in};
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	assign ready = rb_sync_q[1];
	assign idle = (state_q == ST_IDLE);
	assign wr_ctrl = avs_write_in && avs_address_in == OFS_CTRL && idle;

	// bus handshake: control writes stall while the engine runs
	assign avs_waitrequest_out = (avs_read_in && !rd_ack_q)
		|| (avs_write_in && avs_address_in == OFS_CTRL && !idle);
	assign avs_readdata_out = rdata_bus_q;
	assign irq_out = |(irq_stat_q & irq_en_q);

	// register reads answer one cycle after the request
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			rd_ack_q <= 1'b0;
			rdata_bus_q <= 32'h0000_0000;
		end
		else
		begin
			rd_ack_q <= avs_read_in && !rd_ack_q;
			unique case (avs_address_in)
				OFS_ADDR: rdata_bus_q <= 32'(addr_q);
				OFS_WDATA: rdata_bus_q <= {16'h0000, wdata_q};
				OFS_STATUS: rdata_bus_q <= {rdata_q, 10'h000, tog_susp_q,
					tog_main_q, vid_ok_q, vid_q, ready, !idle};
				OFS_IRQ_STAT: rdata_bus_q <= {28'h0000000, irq_stat_q};
				OFS_IRQ_EN: rdata_bus_q <= {28'h0000000, irq_en_q};
				default: rdata_bus_q <= 32'h0000_0000;
			endcase
		end
	end

	// software-written address, data and interrupt enable
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			addr_q <= '0;
			wdata_q <= 16'h0000;
			irq_en_q <= IRQ_RST;
		end
		else if (avs_write_in)
		begin
			if (avs_address_in == OFS_ADDR)
			begin
				addr_q <= ADDR_W'(be_merge(32'(addr_q), avs_writedata_in,
					avs_byteenable_in));
			end
			if (avs_address_in == OFS_WDATA)
			begin
				wdata_q <= 16'(be_merge({16'h0000, wdata_q}, avs_writedata_in,
					avs_byteenable_in));
			end
			if (avs_address_in == OFS_IRQ_EN && avs_byteenable_in[0])
			begin
				irq_en_q <= avs_writedata_in[IRQ_W-1:0];
			end
		end
	end

	// sticky interrupt status, a new event wins over a clear
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			irq_stat_q <= IRQ_RST;
		end
		else if (avs_write_in && avs_address_in == OFS_IRQ_CLR
			&& avs_byteenable_in[0])
		begin
			irq_stat_q <= (irq_stat_q & ~avs_writedata_in[IRQ_W-1:0]) | ev_q;
		end
		else
		begin
			irq_stat_q <= irq_stat_q | ev_q;
		end
	end

	// cycle engine: write strobes, reads, toggle polling, high voltage
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 16'h0000;
			mode_q <= 2'h0;
			poll_q <= 1'b0;
			first_q <= 1'b0;
			vid_q <= 1'b0;
			vid_ok_q <= 1'b0;
			samp_q <= 16'h0000;
			rdata_q <= 16'h0000;
			tog_main_q <= 1'b0;
			tog_susp_q <= 1'b0;
			ev_q <= IRQ_RST;
		end
		else
		begin
			ev_q <= IRQ_RST;
			unique case (state_q)
				ST_IDLE:
				begin
					if (wr_ctrl && avs_writedata_in[CTRL_WRITE])
					begin
						state_q <= ST_WR;
						cnt_q <= 16'(WP_CYC);
						mode_q <= {avs_writedata_in[CTRL_UNPROT],
							avs_writedata_in[CTRL_PROT]};
					end
					else if (wr_ctrl && (avs_writedata_in[CTRL_READ]
						|| avs_writedata_in[CTRL_POLL]))
					begin
						state_q <= ST_RD;
						cnt_q <= 16'(ACC_CYC);
						mode_q <= 2'h0;
						poll_q <= avs_writedata_in[CTRL_POLL];
						first_q <= 1'b1;
						tog_main_q <= 1'b0;
						tog_susp_q <= 1'b0;
					end
					else if (wr_ctrl && avs_writedata_in[CTRL_VID_ON])
					begin
						state_q <= ST_VUP;
						cnt_q <= 16'(RSP_CYC);
						vid_q <= 1'b1;
					end
					else if (wr_ctrl && avs_writedata_in[CTRL_VID_OFF] && vid_q)
					begin
						state_q <= ST_VDN;
					end
				end
				ST_WR:
				begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001)
					begin
						state_q <= ST_GAP;
						cnt_q <= 16'(WPH_CYC);
						ev_q[IRQ_DONE] <= 1'b1;
					end
				end
				ST_RD:
				begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001)
					begin
						state_q <= ST_GAP;
						cnt_q <= 16'(OEPH_CYC); // oe released between reads
						samp_q <= dq_s2_q;
						first_q <= 1'b0;
						if (!poll_q)
						begin
							rdata_q <= dq_s2_q;
							ev_q[IRQ_DONE] <= 1'b1;
						end
						else if (!first_q && samp_q[6] == dq_s2_q[6])
						begin
							// main bit stopped toggling: done
							poll_q <= 1'b0;
							rdata_q <= dq_s2_q;
							ev_q[IRQ_POLL] <= 1'b1;
						end
						else if (!first_q)
						begin
							tog_main_q <= 1'b1;
							tog_susp_q <= tog_susp_q
								| (samp_q[2] ^ dq_s2_q[2]);
						end
					end
				end
				ST_GAP:
				begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001)
					begin
						state_q <= poll_q ? ST_RD : ST_IDLE;
						cnt_q <= 16'(ACC_CYC);
					end
				end
				ST_VUP:
				begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001)
					begin
						state_q <= ST_IDLE; // writes only after setup
						vid_ok_q <= 1'b1;
						ev_q[IRQ_VID_ON] <= 1'b1;
					end
				end
				ST_VDN:
				begin
					if (ready)
					begin
						state_q <= ST_VHOLD;
						cnt_q <= 16'(RRB_CYC); // hold after ready
					end
				end
				ST_VHOLD:
				begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001)
					begin
						state_q <= ST_IDLE;
						vid_q <= 1'b0;
						vid_ok_q <= 1'b0;
						ev_q[IRQ_VID_OFF] <= 1'b1;
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// pin drive from engine state and registers
	always_comb
	begin
		pins_out.addr = FLASH_AW'(addr_q); // any address for polling
		if (mode_q != 2'h0)
		begin
			pins_out.addr = FLASH_AW'(prot_addr(addr_q, mode_q[1]));
		end
		pins_out.dq = wdata_q;
		pins_out.dq_oe = (state_q == ST_WR);
		pins_out.ce_n = !(state_q == ST_WR || state_q == ST_RD);
		pins_out.oe_n = !(state_q == ST_RD);
		pins_out.we_n = !(state_q == ST_WR);
		pins_out.unprotect_high_voltage = vid_q;
	end

	// helper counters for the checks below
	logic [15:0] oe_hi_q, vid_age_q, rdy_age_q;
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			oe_hi_q <= 16'h0000;
			vid_age_q <= 16'h0000;
			rdy_age_q <= 16'h0000;
		end
		else
		begin
			oe_hi_q <= pins_out.oe_n ? oe_hi_q + {15'h0000, oe_hi_q != 16'hFFFF}
				: 16'h0000;
			vid_age_q <= vid_q ? vid_age_q
				+ {15'h0000, vid_age_q != 16'hFFFF} : 16'h0000;
			rdy_age_q <= (vid_q && ready) ? rdy_age_q
				+ {15'h0000, rdy_age_q != 16'hFFFF} : 16'h0000;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);

	poll_gap_a: assert property (
		$fell(pins_out.oe_n) && poll_q && !first_q
			|-> oe_hi_q >= 16'(OEPH_CYC))
		else $error("status reads not separated by oe high time");
	prot_addr_a: assert property (
		!pins_out.we_n && mode_q == 2'h1
			|-> !pins_out.addr[6] && pins_out.addr[1:0] == 2'h2)
		else $error("protect cycle address bits wrong");
	unprot_addr_a: assert property (
		!pins_out.we_n && mode_q[1]
			|-> pins_out.addr[6] && pins_out.addr[1:0] == 2'h2)
		else $error("unprotect cycle address bits wrong");
	vid_setup_a: assert property (
		vid_q && $fell(pins_out.we_n) |-> vid_age_q >= 16'(RSP_CYC))
		else $error("write too soon after high voltage applied");
	vid_hold_a: assert property (
		$fell(vid_q) |-> $past(rdy_age_q) >= 16'(RRB_CYC))
		else $error("high voltage dropped too soon after ready");
	poll_addr_a: assert property (
		!pins_out.oe_n |-> pins_out.addr == FLASH_AW'(addr_q))
		else $error("status read not at programmed address");
	poll_stop_a: assert property (
		$fell(poll_q) |-> $past(samp_q[6]) == $past(dq_s2_q[6])
			##1 irq_stat_q[IRQ_POLL])
		else $error("polling ended while main toggle bit still moving");
endmodule : flash_host_ctl

// >>> design/flash_ctl_pkg.sv
// shared constants, register map and types of the flash host controller
package flash_ctl_pkg;
	localparam int CLK_MHZ = 200;
	localparam int FLASH_AW = 22;
	localparam int FLASH_DW = 16;
	// timing figures and their cycle counts
	localparam int T_WP_NS = 30;
	localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int T_WPH_NS = 30;
	localparam int WPH_CYC = (T_WPH_NS * CLK_MHZ + 999) / 1000;
	localparam int T_ACC_NS = 70;
	localparam int SYNC_CYC = 2;
	localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
	localparam int T_OEPH_NS = 20;
	localparam int OEPH_CYC = (T_OEPH_NS * CLK_MHZ + 999) / 1000;
	localparam int T_RSP_US = 4;
	localparam int RSP_CYC = T_RSP_US * CLK_MHZ;
	localparam int T_RRB_US = 4;
	localparam int RRB_CYC = T_RRB_US * CLK_MHZ;
	// register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_ADDR = 5'h04;
	localparam logic [4:0] OFS_WDATA = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0C;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h10;
	localparam logic [4:0] OFS_IRQ_CLR = 5'h14;
	localparam logic [4:0] OFS_IRQ_EN = 5'h18;
	// control bits
	localparam int CTRL_WRITE = 0;
	localparam int CTRL_READ = 1;
	localparam int CTRL_POLL = 2;
	localparam int CTRL_PROT = 3;
	localparam int CTRL_UNPROT = 4;
	localparam int CTRL_VID_ON = 5;
	localparam int CTRL_VID_OFF = 6;
	// interrupt bits
	localparam int IRQ_DONE = 0;
	localparam int IRQ_POLL = 1;
	localparam int IRQ_VID_ON = 2;
	localparam int IRQ_VID_OFF = 3;
	localparam int IRQ_W = 4;
	localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
	// engine states
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_WR = 7'h02,
		ST_RD = 7'h04,
		ST_GAP = 7'h08,
		ST_VUP = 7'h10,
		ST_VDN = 7'h20,
		ST_VHOLD = 7'h40
	} state_e;
	// pins driven toward the flash
	typedef struct packed {
		logic [FLASH_AW-1:0] addr;
		logic [FLASH_DW-1:0] dq;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic unprotect_high_voltage;
	} flash_pins_s;
endpackage : flash_ctl_pkg

// >>> test/flash_model.sv
// behavioural model of the parallel flash behind the host controller
`timescale 1ns/1ps
module flash_model
	import flash_ctl_pkg::*;
#(
	parameter int PROG_NS = 6000,
	parameter int BUSY_NS = 60,
	parameter int ERASE_NS = 500000000,
	// data word that starts an erase instead of a program; value arbitrary
	parameter logic [FLASH_DW-1:0] ERASE_CODE = 16'h5A5A
)
(
	// pins from the controller
	input flash_pins_s pins_in,
	// answers toward the controller
	output logic [FLASH_DW-1:0] dq_out,
	output logic ready_busy_n_out
);
	logic [FLASH_DW-1:0] mem_q;
	logic [FLASH_DW-1:0] last_q;
	logic tog_q;
	logic sel_q;
	wire logic rd_n = pins_in.oe_n | pins_in.ce_n;
	initial
	begin
		ready_busy_n_out = 1'b1;
		tog_q = 1'b0;
		sel_q = 1'b0;
		mem_q = 16'h0000;
		last_q = 16'h0000;
	end
	// chip select is judged when the strobe falls, as both rise together
	always @(negedge pins_in.we_n)
	begin
		sel_q = (pins_in.ce_n === 1'b0);
	end
	// write strobe end starts the embedded program or erase
	always @(posedge pins_in.we_n)
	begin
		if (sel_q)
		begin
			if (pins_in.dq == ERASE_CODE)
			begin
				mem_q = 16'h0000; // pre-program to zero first
				#(BUSY_NS) ready_busy_n_out = 1'b0;
				#(ERASE_NS) mem_q = 16'hFFFF;
			end
			else
			begin
				mem_q = pins_in.dq;
				#(BUSY_NS) ready_busy_n_out = 1'b0;
				#(PROG_NS);
			end
			ready_busy_n_out = 1'b1;
		end
	end
	// either strobe counts as a status read, at any address
	always @(negedge rd_n)
	begin
		if (!ready_busy_n_out)
			tog_q = ~tog_q;
	end
	// status while busy, true data after; released bus flips
	always @*
	begin
		if (!rd_n && !ready_busy_n_out)
			dq_out = {mem_q[15:8], ~mem_q[7], tog_q, mem_q[5:3],
				1'b1, mem_q[1:0]};
		else if (!rd_n)
			dq_out = mem_q;
		else
			dq_out = ~last_q;
		if (!rd_n)
			last_q = dq_out;
	end
endmodule : flash_model

// >>> test/flash_host_ctl_tb.sv
// self-checking bench of the flash host controller
`timescale 1ns/1ps
module flash_host_ctl_tb;
	import flash_ctl_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [4:0] avs_address_in = 5'h00;
	logic avs_read_in = 1'b0;
	logic avs_write_in = 1'b0;
	logic [31:0] avs_writedata_in = 32'h00000000;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	logic irq_out;
	flash_pins_s pins;
	logic [FLASH_DW-1:0] dq;
	logic rb_n;
	logic [21:0] wa;
	logic [31:0] v;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	// erase-starting data word handed to the model; value arbitrary
	localparam logic [15:0] ERASE_WORD = 16'h5A5A;
	flash_host_ctl uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(4'hF), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
		.pins_out(pins), .dq_in(dq), .ready_busy_n_in(rb_n));
	// erase time shortened to keep the run short
	flash_model #(.ERASE_NS(9000), .ERASE_CODE(ERASE_WORD)) fm (
		.pins_in(pins), .dq_out(dq), .ready_busy_n_out(rb_n));
	// clock
	initial
	begin
		forever #2.5 clk_in = ~clk_in;
	end
	// address seen during write strobes, and the hang limit
	always @(posedge clk_in)
	begin
		if (pins.we_n === 1'b0)
			wa <= pins.addr;
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// request held until a rising edge sees waitrequest low
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= 1'b1;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0)
			@(posedge clk_in);
		avs_write_in <= 1'b0;
	endtask : bus_wr
	// read data taken at the same edge that sees waitrequest low
	task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_in);
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		@(posedge clk_in);
		while (avs_waitrequest_out !== 1'b0)
			@(posedge clk_in);
		d = avs_readdata_out;
		avs_read_in <= 1'b0;
	endtask : bus_rd
	// one engine order, counting cycles until its interrupt
	task automatic run_op(input logic [31:0] c, input int b, output int k);
		bus_wr(OFS_IRQ_EN, 32'h1 << b);
		bus_wr(OFS_CTRL, c);
		k = 0;
		while (irq_out !== 1'b1 && k < 5000)
		begin
			@(posedge clk_in);
			k++;
		end
		chk("irq_raise", 1, irq_out);
		bus_wr(OFS_IRQ_CLR, 32'h0000000F);
	endtask : run_op
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// main sequence
	initial
	begin
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		bus_rd(OFS_IRQ_STAT, v);
		chk("irq_stat_rst", 0, v);
		bus_rd(5'h1C, v);
		chk("unmapped", 0, v);
		bus_wr(OFS_ADDR, 32'h00000123);
		bus_wr(OFS_WDATA, 32'h000000A5);
		bus_rd(OFS_WDATA, v);
		chk("wdata", 32'h000000A5, v);
		run_op(32'h1, IRQ_DONE, n);
		chk("prog_addr", 22'h000123, wa);
		run_op(32'h2, IRQ_DONE, n);
		bus_rd(OFS_STATUS, v);
		chk("busy_dq7", 0, v[23]);
		run_op(32'h4, IRQ_POLL, n);
		chk("poll_time", 1, n > 1000);
		bus_rd(OFS_STATUS, v);
		chk("true_data", 16'h00A5, v[31:16]);
		chk("toggle_seen", 1, v[4]);
		bus_wr(OFS_WDATA, {16'h0000, ERASE_WORD});
		run_op(32'h1, IRQ_DONE, n);
		run_op(32'h2, IRQ_DONE, n);
		bus_rd(OFS_STATUS, v);
		chk("erase_dq7", 1, v[23]);
		run_op(32'h4, IRQ_POLL, n);
		chk("erase_time", 1, n > 1000);
		bus_rd(OFS_STATUS, v);
		chk("erased_data", 16'hFFFF, v[31:16]);
		bus_wr(OFS_WDATA, 32'h000000A5);
		bus_wr(OFS_ADDR, 32'h003FFFFF);
		run_op(32'h9, IRQ_DONE, n);
		chk("protect_addr", 22'h3FFFBE, wa);
		bus_wr(OFS_ADDR, 32'h00000000);
		run_op(32'h11, IRQ_DONE, n);
		chk("unprot_addr", 22'h000042, wa);
		run_op(32'h20, IRQ_VID_ON, n);
		chk("hv_setup", 1, n >= RSP_CYC);
		chk("hv_on", 1, pins.unprotect_high_voltage);
		run_op(32'h1, IRQ_DONE, n);
		chk("hv_write_addr", 22'h000000, wa);
		run_op(32'h40, IRQ_VID_OFF, n);
		chk("hv_hold", 1, n >= RRB_CYC);
		chk("hv_off", 0, pins.unprotect_high_voltage);
		bus_wr(OFS_IRQ_EN, 32'h0);
		bus_wr(OFS_CTRL, 32'h2);
		repeat (40) @(posedge clk_in);
		bus_rd(OFS_IRQ_STAT, v);
		chk("sticky_done", 1, v[IRQ_DONE]);
		chk("irq_masked", 0, irq_out);
		bus_wr(OFS_IRQ_EN, 32'h1);
		@(negedge clk_in);
		chk("irq_enabled", 1, irq_out);
		bus_wr(OFS_IRQ_CLR, 32'h1);
		@(negedge clk_in);
		chk("irq_cleared", 0, irq_out);
		tally_and_finish();
	end
endmodule : flash_host_ctl_tb
